// >>> logic/part_tag_pkg.sv
// constants, register map and carrier types for the partition tag block
package part_tag_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_L3 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_L2 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_L1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_HYP = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CTX = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IDENT = 8'h14;
  // level3_partition_control bits
  localparam int B_EN = 0;
  localparam int B_SDEF = 1;
  localparam int B_FNS = 2;
  localparam int B_TL = 3;
  // level2_partition_control bits (enable copy at B_EN)
  localparam int B_GKT = 1;
  localparam int B_GUT = 2;
  // hypervisor_partition_control bits
  localparam int B_IRT = 0;
  localparam int B_GAL = 1;
  localparam int B_KVM = 2;
  localparam int B_UVM = 3;
  // execution context bits
  localparam int B_NV = 0;
  localparam int B_NV2 = 1;
  localparam int B_E2H = 2;
  localparam int B_SECURE_LEVEL2_ENABLE = 3;
  // partition_capability_ident bits
  localparam int B_CSD = 0;
  localparam int B_CNS = 1;
  localparam int B_SPID = 2;
  // identifier widths and default identifiers
  localparam int PID_W = 16;
  localparam int PMG_W = 8;
  localparam logic [PID_W-1:0] DEF_PID_S = 16'h0;
  localparam logic [PID_W-1:0] DEF_PID_NS = 16'h0;
  localparam logic [PMG_W-1:0] DEF_PMG = 8'h0;

  typedef enum logic [2:0] {
    SEL_L3 = 3'h0, SEL_L2 = 3'h1, SEL_L1 = 3'h2, SEL_ALIAS = 3'h3,
    SEL_HYP = 3'h4, SEL_VMAP = 3'h5, SEL_IDENT = 3'h6
  } reg_sel_t;

  typedef enum logic [2:0] {
    ACC_OK = 3'h0, ACC_UNDEF = 3'h1, ACC_TRAP3 = 3'h2,
    ACC_TRAP2 = 3'h3, ACC_MEM = 3'h4
  } acc_res_t;

  typedef enum logic {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_t;

  typedef struct packed {
    logic valid;
    logic secure;
    logic [PID_W-1:0] pid;
    logic [PMG_W-1:0] monitor_group;
  } req_t;

  typedef struct packed {
    logic valid;
    logic [PID_W-1:0] pid;
    logic [PMG_W-1:0] monitor_group;
    logic ns;
  } tag_t;

  typedef struct packed {
    logic valid;
    logic [1:0] el;
    logic secure;
    reg_sel_t sel;
  } acc_req_t;

  typedef struct packed {
    logic valid;
    acc_res_t res;
  } acc_ans_t;
endpackage : part_tag_pkg

// >>> logic/part_tag_ctrl.sv
// partition identifier tagging, default overrides and register trap control
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - without secure-default capability, that bit reads zero, ignores writes, has no effect
// - secure-default on: secure requests take default secure id, or non-secure if forced
// - secure-default on: secure requests take the default monitor group
// - secure-default off: identifiers come from the normal selection path
// - secure-default bit is not reset; software must program it
// - global enable off: every request carries identifier 0 and group 0
// - enable and secure-default on: secure requests carry 0 and 0
// - lower-level trap set: level 1/2 register accesses trap to level 3
// - lower-level trap outranks hypervisor-configured traps
// - nested virt changes only level 1; with lower trap, level 2 traps to 3
// - enhanced nested virt turns trapped level-2 accesses from level 1 into memory
// - no secure identifiers: force bit reads one, space flag always 1
// - writable force bit selects secure requests' space flag directly
// - without force capability, the force bit reads zero and has no effect
// - writable force bit clears to 0 on every reset
// - otherwise the force bit is left unknown by reset
// - reset clears the global enable and sets the lower-level trap
// - guest and ident traps keep value with level 3, reset to 1 without it
// - no level 3: its register undefined, lower trap acts as 0, enable moves down
// - no level 2: its registers read zero from level 3, undefined elsewhere
// - non-secure-only level 2: its registers reachable from 3 or non-secure 2
// - secure level 2 absent or disabled behaves like the non-secure-only case
// - enable writable only at the highest level; lower levels read a copy
module part_tag_ctrl
  import part_tag_pkg::*;
#(
  parameter bit HAS_EL3 = 1'b1,
  parameter bit HAS_EL2 = 1'b1,
  parameter bit HAS_SEL2 = 1'b1,
  parameter bit CAP_SECURE_DEFAULT_OVERRIDE = 1'b1,
  parameter bit CAP_SECURE_TO_NONSECURE_OVERRIDE = 1'b1,
  parameter bit SECURE_TO_NONSECURE_OVERRIDE_WRITABLE = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire req_t req_in,
  output tag_t tag_out,
  input wire acc_req_t acc_in,
  output acc_ans_t acc_out
);

  typedef struct packed {
    wr_state_t wst;
    logic awready;
    logic wready;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    logic sdef;
    logic fns;
    logic tl;
    logic gkt;
    logic gut;
    logic irt;
    logic gal;
    logic kvm;
    logic uvm;
    logic nv;
    logic nv2;
    logic e2h;
    logic secure_level2_enable;
    tag_t tag;
    acc_ans_t acc;
  } st_t;

  st_t st_q;
  st_t st_d;

  // secure state without its own level 2 falls back to non-secure-only rules
  function automatic logic el2_on(input logic secure, input logic secure_level2_enable);
    el2_on = HAS_EL2 && (!secure || (HAS_SEL2 && secure_level2_enable));
  endfunction : el2_on

  // effective lower-level trap: inert without level 3
  function automatic logic trap_low(input logic tl);
    trap_low = HAS_EL3 && tl;
  endfunction : trap_low

  // readable image of one register; level-2 registers read zero without level 2
  function automatic logic [31:0] reg_image(input st_t s, input logic [ADDR_W-1:0] a,
                                            output logic hit);
    logic [31:0] v;
    v = 32'h0;
    hit = 1'b1;
    case (a)
      OFF_L3:
      begin
        hit = HAS_EL3;
        v[B_EN] = s.en;
        v[B_SDEF] = CAP_SECURE_DEFAULT_OVERRIDE && s.sdef;
        v[B_FNS] = CAP_SECURE_TO_NONSECURE_OVERRIDE && (s.fns || !SECURE_TO_NONSECURE_OVERRIDE_WRITABLE);
        v[B_TL] = s.tl;
      end
      OFF_L2:
      begin
        v[B_EN] = HAS_EL2 && s.en;
        v[B_GKT] = HAS_EL2 && s.gkt;
        v[B_GUT] = HAS_EL2 && s.gut;
      end
      OFF_L1: v[B_EN] = s.en;
      OFF_HYP:
      begin
        v[B_IRT] = HAS_EL2 && s.irt;
        v[B_GAL] = HAS_EL2 && s.gal;
        v[B_KVM] = HAS_EL2 && s.kvm;
        v[B_UVM] = HAS_EL2 && s.uvm;
      end
      OFF_CTX:
      begin
        v[B_NV] = s.nv;
        v[B_NV2] = s.nv2;
        v[B_E2H] = s.e2h;
        v[B_SECURE_LEVEL2_ENABLE] = s.secure_level2_enable;
      end
      OFF_IDENT:
      begin
        v[B_CSD] = CAP_SECURE_DEFAULT_OVERRIDE;
        v[B_CNS] = CAP_SECURE_TO_NONSECURE_OVERRIDE;
        v[B_SPID] = !(CAP_SECURE_TO_NONSECURE_OVERRIDE && !SECURE_TO_NONSECURE_OVERRIDE_WRITABLE);
      end
      default: hit = 1'b0;
    endcase
    return v;
  endfunction : reg_image

  // register access check for a system-register access from software
  function automatic acc_res_t check(input st_t s, input acc_req_t r);
    acc_res_t res;
    logic l2;
    logic l2reg;
    res = ACC_OK;
    l2 = el2_on(r.secure, s.secure_level2_enable);
    l2reg = (r.sel == SEL_L2) || (r.sel == SEL_HYP) || (r.sel == SEL_VMAP)
            || (r.sel == SEL_ALIAS);
    case (r.el)
      2'h3:
      begin
        // level 3 keeps full access; alias exists only with level 2, its own register only with level 3
        if (r.sel == SEL_ALIAS && !HAS_EL2)
          res = ACC_UNDEF;
        else if (r.sel == SEL_L3 && !HAS_EL3)
          res = ACC_UNDEF;
      end
      2'h2:
      begin
        if (!l2 || r.sel == SEL_L3)
          res = ACC_UNDEF;
        else if (r.sel == SEL_ALIAS && !s.e2h)
          res = ACC_UNDEF;
        else if (trap_low(s.tl))
          res = ACC_TRAP3;
      end
      2'h1:
      begin
        if (r.sel == SEL_L3)
          res = ACC_UNDEF;
        else if (l2reg)
        begin
          // nested virt only reshapes level-1 accesses
          if (l2 && s.nv && s.nv2)
            res = ACC_MEM;
          else if (l2 && s.nv)
            res = trap_low(s.tl) ? ACC_TRAP3 : ACC_TRAP2;
          else
            res = ACC_UNDEF;
        end
        else if (trap_low(s.tl))
          res = ACC_TRAP3;
        else if (r.sel == SEL_L1 && l2 && s.gkt)
          res = ACC_TRAP2;
        else if (r.sel == SEL_IDENT && l2 && s.irt)
          res = ACC_TRAP2;
      end
      default: res = ACC_UNDEF;
    endcase
    return res;
  endfunction : check

  // identifier selection: enable, then secure default, then force override
  function automatic tag_t select_tag(input st_t s, input req_t r);
    tag_t t;
    logic sd;
    logic fns;
    sd = CAP_SECURE_DEFAULT_OVERRIDE && s.sdef;
    fns = CAP_SECURE_TO_NONSECURE_OVERRIDE && (s.fns || !SECURE_TO_NONSECURE_OVERRIDE_WRITABLE);
    t.valid = r.valid;
    t.ns = !r.secure || fns;
    if (!s.en)
    begin
      t.pid = '0;
      t.monitor_group = '0;
    end
    else if (r.secure && sd)
    begin
      t.pid = fns ? DEF_PID_NS : DEF_PID_S;
      t.monitor_group = DEF_PMG;
    end
    else
    begin
      t.pid = r.pid;
      t.monitor_group = r.monitor_group;
    end
    return t;
  endfunction : select_tag

  // next-state: bus slave, register writes, tagging and access checks
  always_comb
  begin
    logic hit;
    logic [31:0] img;
    logic [7:0] b;
    hit = 1'b0;
    img = 32'h0;
    b = 8'h0;
    st_d = st_q;
    // write address and data may arrive in either order
    if (awvalid && st_q.awready)
    begin
      st_d.waddr = awaddr;
      st_d.awready = 1'b0;
    end
    if (wvalid && st_q.wready)
    begin
      st_d.wdat = wdata;
      st_d.wstb = wstrb;
      st_d.wready = 1'b0;
    end
    case (st_q.wst)
      WR_COLLECT:
      begin
        if (!st_q.awready && !st_q.wready)
        begin
          img = reg_image(st_q, st_q.waddr, hit);
          b = st_q.wdat[7:0];
          st_d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
          st_d.bvalid = 1'b1;
          st_d.wst = WR_RESP;
          if (hit && st_q.wstb[0])
          begin
            case (st_q.waddr)
              OFF_L3:
              begin
                st_d.en = b[B_EN];
                if (CAP_SECURE_DEFAULT_OVERRIDE)
                  st_d.sdef = b[B_SDEF];
                if (CAP_SECURE_TO_NONSECURE_OVERRIDE && SECURE_TO_NONSECURE_OVERRIDE_WRITABLE)
                  st_d.fns = b[B_FNS];
                st_d.tl = b[B_TL];
              end
              OFF_L2:
              begin
                if (HAS_EL2)
                begin
                  if (!HAS_EL3)
                    st_d.en = b[B_EN];
                  st_d.gkt = b[B_GKT];
                  st_d.gut = b[B_GUT];
                end
              end
              OFF_L1:
              begin
                if (!HAS_EL3 && !HAS_EL2)
                  st_d.en = b[B_EN];
              end
              OFF_HYP:
              begin
                if (HAS_EL2)
                begin
                  st_d.irt = b[B_IRT];
                  st_d.gal = b[B_GAL];
                  st_d.kvm = b[B_KVM];
                  st_d.uvm = b[B_UVM];
                end
              end
              OFF_CTX:
              begin
                st_d.nv = b[B_NV];
                st_d.nv2 = b[B_NV2];
                st_d.e2h = b[B_E2H];
                st_d.secure_level2_enable = b[B_SECURE_LEVEL2_ENABLE];
              end
              default: st_d.bresp = RESP_OKAY; // read-only ident
            endcase
          end
        end
      end
      WR_RESP:
      begin
        if (bready)
        begin
          st_d.bvalid = 1'b0;
          st_d.awready = 1'b1;
          st_d.wready = 1'b1;
          st_d.wst = WR_COLLECT;
        end
      end
      default: st_d.wst = WR_COLLECT;
    endcase
    // read channel: one outstanding read, answered the edge after address
    if (arvalid && st_q.arready)
    begin
      st_d.rdata = reg_image(st_q, araddr, hit);
      st_d.rresp = hit ? RESP_OKAY : RESP_SLVERR;
      st_d.rvalid = 1'b1;
      st_d.arready = 1'b0;
    end
    else if (st_q.rvalid && rready)
    begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end
    // one request tagged per cycle, answer one cycle later
    st_d.tag = select_tag(st_q, req_in);
    st_d.acc.valid = acc_in.valid;
    st_d.acc.res = check(st_q, acc_in);
  end

  // synchronous reset; unknown-after-reset bits are left untouched on purpose
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q.wst <= WR_COLLECT;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.waddr <= '0;
      st_q.wdat <= 32'h0;
      st_q.wstb <= 4'h0;
      st_q.bvalid <= 1'b0;
      st_q.bresp <= RESP_OKAY;
      st_q.arready <= 1'b1;
      st_q.rvalid <= 1'b0;
      st_q.rdata <= 32'h0;
      st_q.rresp <= RESP_OKAY;
      st_q.en <= 1'b0;
      st_q.tl <= 1'b1;
      st_q.sdef <= st_q.sdef;
      st_q.fns <= SECURE_TO_NONSECURE_OVERRIDE_WRITABLE ? 1'b0 : st_q.fns;
      st_q.gkt <= HAS_EL3 ? st_q.gkt : 1'b1;
      st_q.gut <= HAS_EL3 ? st_q.gut : 1'b1;
      st_q.irt <= HAS_EL3 ? st_q.irt : 1'b1;
      st_q.gal <= 1'b0;
      st_q.kvm <= 1'b0;
      st_q.uvm <= 1'b0;
      st_q.nv <= 1'b0;
      st_q.nv2 <= 1'b0;
      st_q.e2h <= 1'b0;
      st_q.secure_level2_enable <= 1'b0;
      st_q.tag <= '0;
      st_q.acc <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // every output straight from the state flops
  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
  assign tag_out = st_q.tag;
  assign acc_out = st_q.acc;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence secure_req_s;
    req_in.valid && req_in.secure;
  endsequence

  sequence default_tag_s;
    // force bit as it stood when the request was sampled, not one cycle later
    tag_out.monitor_group == DEF_PMG
      && tag_out.pid == ((CAP_SECURE_TO_NONSECURE_OVERRIDE && $past(st_q.fns)) ? DEF_PID_NS : DEF_PID_S);
  endsequence

  enable_off_zero_a: assert property (
    (req_in.valid && !st_q.en) |=> (tag_out.pid == '0 && tag_out.monitor_group == '0))
    else $error("disabled request not tagged zero");

  secure_default_a: assert property (
    (secure_req_s and (st_q.en && CAP_SECURE_DEFAULT_OVERRIDE && st_q.sdef && $stable(st_q.fns)))
    |=> default_tag_s)
    else $error("secure default identifiers not applied");

  normal_path_a: assert property (
    (req_in.valid && st_q.en && !(req_in.secure && CAP_SECURE_DEFAULT_OVERRIDE && st_q.sdef))
    |=> (tag_out.pid == $past(req_in.pid) && tag_out.monitor_group == $past(req_in.monitor_group)))
    else $error("normal identifiers not passed");

  space_flag_a: assert property (
    req_in.valid |=> tag_out.ns == (!$past(req_in.secure)
      || (CAP_SECURE_TO_NONSECURE_OVERRIDE && ($past(st_q.fns) || !SECURE_TO_NONSECURE_OVERRIDE_WRITABLE))))
    else $error("space flag wrong");

  lower_trap_a: assert property (
    (acc_in.valid && acc_in.el == 2'h1 && HAS_EL3 && st_q.tl && acc_in.sel == SEL_L1)
    |=> acc_out.res == ACC_TRAP3)
    else $error("lower trap lost priority");

  nested_mem_a: assert property (
    (acc_in.valid && acc_in.el == 2'h1 && acc_in.sel == SEL_HYP && !acc_in.secure
     && HAS_EL2 && st_q.nv && st_q.nv2) |=> acc_out.res == ACC_MEM)
    else $error("nested access not sent to memory");

  reset_values_a: assert property (
    $rose(aresetn) |-> (!st_q.en && st_q.tl && !tag_out.valid))
    else $error("reset values wrong");

  force_reset_a: assert property (
    ($rose(aresetn) && SECURE_TO_NONSECURE_OVERRIDE_WRITABLE) |-> !st_q.fns)
    else $error("force bit not cleared by reset");

  write_resp_hold_a: assert property (
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped");

endmodule : part_tag_ctrl
`default_nettype wire

// >>> bench/tag_sink.sv
// memory-side model that consumes tagged requests
`timescale 1ns/1ns
`default_nettype none
module tag_sink
  import part_tag_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire tag_t tag_in,
  output logic [15:0] seen_count
);
  // one tag taken per valid cycle; this path has no backpressure, so none is modelled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seen_count <= 16'h0;
    else if (tag_in.valid)
      seen_count <= seen_count + 16'h1;
  end
endmodule : tag_sink
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the partition tag controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  import part_tag_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] seen, sent;
  req_t req_in;
  tag_t tag_out;
  acc_req_t acc_in;
  acc_ans_t acc_out;
  int fail_count, comparisons;

  part_tag_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .req_in(req_in), .tag_out(tag_out), .acc_in(acc_in), .acc_out(acc_out));
  tag_sink sink (.aclk(aclk), .aresetn(aresetn), .tag_in(tag_out), .seen_count(seen));

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // exact four-state comparison
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic conclude();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic hang();
    fail_count++;
    $display("mismatch bus answer expected response seen none");
    conclude();
  endtask : hang

  // write one word; address and data offered together, each released when taken
  task automatic wchk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (n == 20)
      hang();
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wchk

  // read one word and compare the masked data and the response
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    if (n == 20)
      hang();
    cmp("rdata", e, rdata & m);
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rchk

  // one request in, its tag checked the cycle after
  task automatic tag(input logic s, input logic [15:0] p, input logic [7:0] g,
                     input logic [25:0] e);
    @(posedge aclk);
    req_in <= '{1'b1, s, p, g};
    @(posedge aclk);
    req_in <= '0;
    sent++;
    #1 cmp("tag", {6'h0, e}, {6'h0, tag_out});
  endtask : tag

  // one register access check, answer the cycle after
  task automatic acc(input logic [1:0] el, input logic s, input reg_sel_t r, input acc_res_t e);
    @(posedge aclk);
    acc_in <= '{1'b1, el, s, r};
    @(posedge aclk);
    acc_in <= '0;
    #1 cmp("access", {28'h0, 1'b1, e}, {28'h0, acc_out});
  endtask : acc

  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    req_in = '0;
    acc_in = '0;
    sent = 16'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state; secure-default bit is left unknown, so it is masked out
    rchk(OFF_L3, 32'hd, 32'h8, RESP_OKAY);
    rchk(8'h18, 32'hffffffff, 32'h0, RESP_SLVERR);
    wchk(8'h18, 32'h1, 4'hf, RESP_SLVERR);
    // enable off: identifiers zero, space flag follows the state
    tag(1'b1, 16'h1234, 8'h56, {1'b1, 16'h0, 8'h0, 1'b0});
    tag(1'b0, 16'h1234, 8'h56, {1'b1, 16'h0, 8'h0, 1'b1});
    // lower trap set by reset
    acc(2'd1, 1'b0, SEL_L1, ACC_TRAP3);
    acc(2'd2, 1'b0, SEL_L2, ACC_TRAP3);
    acc(2'd3, 1'b0, SEL_L3, ACC_OK);
    acc(2'd1, 1'b0, SEL_L3, ACC_UNDEF);
    acc(2'd0, 1'b0, SEL_L1, ACC_UNDEF);
    // guest kernel trap set: lower trap still wins until cleared
    wchk(OFF_L2, 32'h2, 4'hf, RESP_OKAY);
    acc(2'd1, 1'b0, SEL_L1, ACC_TRAP3);
    wchk(OFF_L3, 32'h1, 4'hf, RESP_OKAY);
    acc(2'd1, 1'b0, SEL_L1, ACC_TRAP2);
    acc(2'd2, 1'b0, SEL_L2, ACC_OK);
    acc(2'd1, 1'b0, SEL_HYP, ACC_UNDEF);
    // nested virtualization steps
    wchk(OFF_CTX, 32'h1, 4'hf, RESP_OKAY);
    acc(2'd1, 1'b0, SEL_HYP, ACC_TRAP2);
    acc(2'd2, 1'b0, SEL_L2, ACC_OK);
    wchk(OFF_L3, 32'h9, 4'hf, RESP_OKAY);
    acc(2'd1, 1'b0, SEL_HYP, ACC_TRAP3);
    wchk(OFF_CTX, 32'h3, 4'hf, RESP_OKAY);
    acc(2'd1, 1'b0, SEL_VMAP, ACC_MEM);
    acc(2'd2, 1'b1, SEL_L2, ACC_UNDEF);
    // enabled, normal path
    tag(1'b1, 16'h1234, 8'h56, {1'b1, 16'h1234, 8'h56, 1'b0});
    tag(1'b0, 16'habcd, 8'hef, {1'b1, 16'habcd, 8'hef, 1'b1});
    // secure default on
    wchk(OFF_L3, 32'h3, 4'hf, RESP_OKAY);
    tag(1'b1, 16'h1234, 8'h56, {1'b1, DEF_PID_S, DEF_PMG, 1'b0});
    tag(1'b0, 16'h1234, 8'h56, {1'b1, 16'h1234, 8'h56, 1'b1});
    // force override together with and without secure default
    wchk(OFF_L3, 32'h7, 4'hf, RESP_OKAY);
    tag(1'b1, 16'h1234, 8'h56, {1'b1, DEF_PID_NS, DEF_PMG, 1'b1});
    wchk(OFF_L3, 32'h5, 4'hf, RESP_OKAY);
    tag(1'b1, 16'h1234, 8'h56, {1'b1, 16'h1234, 8'h56, 1'b1});
    wchk(OFF_L3, 32'h6, 4'hf, RESP_OKAY);
    tag(1'b1, 16'h1234, 8'h56, {1'b1, 16'h0, 8'h0, 1'b1});
    // enable copies are read-only below the top level
    wchk(OFF_L2, 32'h3, 4'hf, RESP_OKAY);
    rchk(OFF_L2, 32'h1, 32'h0, RESP_OKAY);
    wchk(OFF_L3, 32'h5, 4'hf, RESP_OKAY);
    rchk(OFF_L1, 32'h1, 32'h1, RESP_OKAY);
    // byte 0 not strobed: no change
    wchk(OFF_L3, 32'h0, 4'he, RESP_OKAY);
    rchk(OFF_L3, 32'h5, 32'h5, RESP_OKAY);
    // ident trap from the hypervisor control, capability word, alias without host bit
    wchk(OFF_HYP, 32'h1, 4'hf, RESP_OKAY);
    acc(2'd1, 1'b0, SEL_IDENT, ACC_TRAP2);
    acc(2'd2, 1'b0, SEL_ALIAS, ACC_UNDEF);
    rchk(OFF_IDENT, 32'h7, 32'h7, RESP_OKAY);
    cmp("sink count", {16'h0, sent}, {16'h0, seen});
    // second reset in mid-run; guest trap kept because level 3 exists
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_L3, 32'hd, 32'h8, RESP_OKAY);
    rchk(OFF_L2, 32'h2, 32'h2, RESP_OKAY);
    rchk(OFF_HYP, 32'h1, 32'h1, RESP_OKAY);
    conclude();
  end
endmodule : tb
`default_nettype wire
